// ==== pkg/tws_pkg.sv ====
package tws_pkg;

// ==========================================
// Timing
localparam int CLK_NS = 10;
localparam int SPIKE_NS = 50;
localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
// Half of the fixed 16-cycle part of the clock-line period
localparam logic [15:0] HALF_BASE = 16'h0008;
// High phase waits this long for the filtered line before calling it a stretch
localparam logic [15:0] SCL_SEEN_CYC = 16'h000c;

// ==========================================
// Addressing
localparam int ADDR_W = 7;
localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

// ==========================================
// Status codes, bit 0 of the address-sent and data-byte codes carries a received not-acknowledge
localparam logic [7:0] ST_NONE = 8'hff;
localparam logic [7:0] ST_BUS_ERR = 8'h01;
localparam logic [7:0] ST_START = 8'h10;
localparam logic [7:0] ST_RSTART = 8'h12;
localparam logic [7:0] ST_MT_ADDR = 8'h20;
localparam logic [7:0] ST_MT_DATA = 8'h22;
localparam logic [7:0] ST_ARB_LOST = 8'h30;
localparam logic [7:0] ST_MR_ADDR = 8'h40;
localparam logic [7:0] ST_MR_DATA = 8'h42;
localparam logic [7:0] ST_SLV_ADDR = 8'h60;
localparam logic [7:0] ST_SLV_GEN = 8'h62;
localparam logic [7:0] ST_SLV_RX = 8'h64;
localparam logic [7:0] ST_SLV_STOP = 8'h68;
localparam logic [7:0] ST_SLV_TX = 8'h70;

// ==========================================
// Controller states
typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_MSTART = 7'h02,
    S_MBIT = 7'h04,
    S_MWAIT = 7'h08,
    S_MSTOP = 7'h10,
    S_SLV = 7'h20,
    S_SWAIT = 7'h40
} tws_state_t;

// Half period: full period is 16 + 2 * divider * 4^prescaler cycles
function automatic logic [15:0] tws_half(input logic [7:0] div, input logic [1:0] ps);
    tws_half = HALF_BASE + ({8'h00, div} << {ps, 1'b0});
endfunction : tws_half

endpackage : tws_pkg

// ==== hdl/tws_spike_filter.sv ====
`timescale 1ns/10ps
module tws_spike_filter
    import tws_pkg::*;
#(
    parameter int STABLE_CYC = SPIKE_CYC
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic clean
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [7:0] cnt;
        logic clean;
    } tws_filt_t;

    localparam tws_filt_t RST_VAL = '{sync1: 1'b1, sync2: 1'b1, cnt: 8'h00, clean: 1'b1};

    tws_filt_t s;
    tws_filt_t next_s;

    if (STABLE_CYC < 1 || STABLE_CYC > 200)
    begin : g_bad_stable
        $error("tws_spike_filter: STABLE_CYC out of range");
    end

    // ==========================================
    // Level must differ for STABLE_CYC+1 samples before it is taken
    always_comb
    begin
        next_s = s;
        next_s.sync1 = pinIn;
        next_s.sync2 = s.sync1;
        if (s.sync2 == s.clean)
        begin
            next_s.cnt = 8'h00;
        end
        else if (s.cnt == 8'(STABLE_CYC))
        begin
            next_s.clean = s.sync2;
            next_s.cnt = 8'h00;
        end
        else
        begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            s <= RST_VAL;
        else
            s <= next_s;
    end

    assign clean = s.clean;

endmodule : tws_spike_filter

// ==== hdl/tws_controller.sv ====
// Notes on behaviour
// - Spikes under 50 ns on either bus line never reach the bus logic.
// - Master clock period is 16 plus twice divider times four to the power of prescaler, in clocks.
// - Slave path ignores divider settings; needs clock sixteen times the bus clock.
// - Master waits while a slave stretches the clock low.
// - One byte register holds next byte to send and last byte received.
// - Hidden acknowledge bit: chosen by control when receiving, reported when sending.
// - Start, repeated start and stop are generated and detected, also asleep.
// - Initiating master watches the data line and reports lost arbitration.
// - Received address byte compared against the seven-bit own address.
// - With general call enabled, the all-zero address also counts as addressed.
// - Address match raises an event; acknowledge follows the control setting.
// - Address compare keeps working asleep; a match requests wake-up.
// - Another wake source during an address match aborts to idle.
// - Event flag sets first; status code loads on the next clock.
// - Status reads the no-information code from the clock after the flag is clear.
// - Clock line held low while the event flag stays set, except after lost arbitration, bus error or slave stop/restart.
// - Event after start or repeated start sent and after address sent.
// - Event after lost arbitration and after every received data byte.
// - Event when addressed, and on stop or restart while addressed as slave.
// - Start or stop inside a byte is a bus error with an event.
// - Rates up to 400 kHz, seven-bit addresses giving 128 slaves.
// - Address packet is seven address bits, read bit (one), acknowledge.
// - Address zero is the general call address.
// - Receiver acknowledges by pulling data low on the ninth clock.
// - Bytes travel most significant bit first.
`timescale 1ns/10ps
module tws_controller
    import tws_pkg::*;
#(
    parameter int FILTER_CYC = SPIKE_CYC
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic startReq,
    input wire logic stopReq,
    input wire logic ackEnable,
    input wire logic clearEvent,
    input wire logic dataLoad,
    input wire logic [7:0] dataIn,
    input wire logic [6:0] ownAddr,
    input wire logic generalCallEnable,
    input wire logic [7:0] bitRateDivider,
    input wire logic [1:0] prescalerSelect,
    input wire logic sleeping,
    input wire logic otherWake,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe,
    output logic eventFlag,
    output logic [7:0] status,
    output logic [7:0] dataOut,
    output logic wakeReq,
    output logic busBusy
);

    typedef struct packed {
        tws_state_t st;
        logic [15:0] cnt;
        logic [3:0] bitCnt;
        logic [7:0] shreg;
        logic ackBit;
        logic sclPrev;
        logic sdaPrev;
        logic evFlag;
        logic [7:0] evCode;
        logic [7:0] status;
        logic sclOe;
        logic sdaOe;
        logic lineLow;
        logic busy;
        logic own;
        logic mTx;
        logic firstByte;
        logic setDone;
        logic slvMatch;
        logic slvTx;
        logic slvData;
        logic wake;
    } tws_regs_t;

    localparam tws_regs_t RST_VAL = '{st: S_IDLE, status: ST_NONE, evCode: ST_NONE,
        sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};

    if (FILTER_CYC + 4 > int'(SCL_SEEN_CYC))
    begin : g_bad_filter
        $error("tws_controller: filter latency exceeds stretch window");
    end

    tws_regs_t s;
    tws_regs_t n;
    logic sclF;
    logic sdaF;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    logic addrOwn;
    logic addrGen;
    logic [15:0] half;
    logic [15:0] halfEnd;
    logic setEv;
    logic [7:0] code;

    // ==========================================
    // Line inputs
    tws_spike_filter #(.STABLE_CYC(FILTER_CYC)) u_scl_filt
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(sclIn),
        .clean(sclF)
    );

    tws_spike_filter #(.STABLE_CYC(FILTER_CYC)) u_sda_filt
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(sdaIn),
        .clean(sdaF)
    );

    assign sclRise = sclF & ~s.sclPrev;
    assign sclFall = ~sclF & s.sclPrev;
    // Both lines share one filter latency, so their order is kept
    assign startDet = sclF & s.sclPrev & ~sdaF & s.sdaPrev;
    assign stopDet = sclF & s.sclPrev & sdaF & ~s.sdaPrev;
    assign addrOwn = (s.shreg[7:1] == ownAddr);
    assign addrGen = generalCallEnable && (s.shreg[7:1] == GEN_CALL_ADDR);
    assign half = tws_half(bitRateDivider, prescalerSelect);
    // Count starts at zero, so a bit phase ends one short of half
    assign halfEnd = half - 16'h0001;

    // ==========================================
    // Next state
    always_comb
    begin
        n = s;
        setEv = 1'b0;
        code = ST_NONE;
        n.sclPrev = sclF;
        n.sdaPrev = sdaF;
        n.status = s.evFlag ? s.evCode : ST_NONE;
        if (startDet)
            n.busy = 1'b1;
        else if (stopDet)
            n.busy = 1'b0;
        if (!sleeping)
            n.wake = 1'b0;
        if (dataLoad && s.evFlag)
            n.shreg = dataIn;
        case (s.st)
            S_IDLE:
            begin
                n.sclOe = 1'b0;
                n.sdaOe = 1'b0;
                n.own = 1'b0;
                n.slvMatch = 1'b0;
                if (startReq && !s.busy && !s.evFlag)
                begin
                    n.st = S_MSTART;
                    n.cnt = 16'h0000;
                end
                else if (startDet)
                begin
                    n.st = S_SLV;
                    n.bitCnt = 4'h0;
                    n.slvData = 1'b0;
                    n.slvTx = 1'b0;
                end
            end
            S_MSTART:
            begin
                n.cnt = s.cnt + 16'h0001;
                if (s.sclOe)
                begin
                    // Data is released while the clock is low first
                    if (s.cnt >= half)
                    begin
                        n.sclOe = 1'b0;
                        n.cnt = 16'h0000;
                    end
                end
                else if (!s.sdaOe)
                begin
                    if (s.cnt >= half && sclF)
                    begin
                        n.sdaOe = 1'b1;
                        n.cnt = 16'h0000;
                    end
                end
                else if (s.cnt >= half)
                begin
                    n.sclOe = 1'b1;
                    n.cnt = 16'h0000;
                    setEv = 1'b1;
                    code = s.own ? ST_RSTART : ST_START;
                    n.own = 1'b1;
                    n.firstByte = 1'b1;
                    n.st = S_MWAIT;
                end
            end
            S_MWAIT:
            begin
                n.sclOe = 1'b1;
                if (clearEvent && s.evFlag)
                begin
                    n.cnt = 16'h0000;
                    n.setDone = 1'b0;
                    if (stopReq)
                    begin
                        n.st = S_MSTOP;
                        n.sdaOe = 1'b1;
                    end
                    else if (startReq)
                    begin
                        n.st = S_MSTART;
                        n.sdaOe = 1'b0;
                    end
                    else
                    begin
                        n.st = S_MBIT;
                        n.bitCnt = 4'h0;
                        if (s.firstByte)
                            n.mTx = 1'b1;
                    end
                end
            end
            S_MBIT:
            begin
                if (s.sclOe)
                begin
                    n.cnt = s.cnt + 16'h0001;
                    // Data changes only once the filtered clock is low
                    if (!sclF && !s.setDone)
                    begin
                        n.setDone = 1'b1;
                        if (s.bitCnt < 4'h8)
                            n.sdaOe = s.mTx & ~s.shreg[7];
                        else
                            n.sdaOe = ~s.mTx & ackEnable;
                    end
                    if (s.setDone && s.cnt >= halfEnd)
                    begin
                        n.sclOe = 1'b0;
                        n.cnt = 16'h0000;
                    end
                end
                else
                begin
                    if (!sclF && s.cnt == SCL_SEEN_CYC)
                        n.cnt = s.cnt;
                    else
                        n.cnt = s.cnt + 16'h0001;
                    if (startDet || stopDet)
                    begin
                        setEv = 1'b1;
                        code = ST_BUS_ERR;
                        n.sdaOe = 1'b0;
                        n.own = 1'b0;
                        n.st = S_IDLE;
                    end
                    else if (sclRise)
                    begin
                        if (s.bitCnt < 4'h8)
                        begin
                            n.shreg = {s.shreg[6:0], sdaF};
                            if (s.mTx && !s.sdaOe && !sdaF)
                            begin
                                setEv = 1'b1;
                                code = ST_ARB_LOST;
                                n.own = 1'b0;
                                n.st = S_IDLE;
                            end
                        end
                        else
                        begin
                            n.ackBit = sdaF;
                        end
                    end
                    else if (s.cnt >= halfEnd && sclF)
                    begin
                        n.sclOe = 1'b1;
                        n.cnt = 16'h0000;
                        n.setDone = 1'b0;
                        n.bitCnt = s.bitCnt + 4'h1;
                        if (s.bitCnt == 4'h8)
                        begin
                            setEv = 1'b1;
                            n.st = S_MWAIT;
                            n.firstByte = 1'b0;
                            if (s.firstByte)
                            begin
                                n.mTx = ~s.shreg[0];
                                code = (s.shreg[0] ? ST_MR_ADDR : ST_MT_ADDR) | {7'h00, s.ackBit};
                            end
                            else
                            begin
                                code = (s.mTx ? ST_MT_DATA : ST_MR_DATA) | {7'h00, s.ackBit};
                            end
                        end
                    end
                end
            end
            S_MSTOP:
            begin
                if (s.sclOe)
                begin
                    n.sdaOe = 1'b1;
                    n.cnt = s.cnt + 16'h0001;
                    if (!sclF && s.cnt >= half)
                    begin
                        n.sclOe = 1'b0;
                        n.cnt = 16'h0000;
                    end
                end
                else if (sclF)
                begin
                    n.cnt = s.cnt + 16'h0001;
                    if (s.cnt >= half)
                    begin
                        n.sdaOe = 1'b0;
                        n.own = 1'b0;
                        n.st = S_IDLE;
                    end
                end
            end
            S_SLV:
            begin
                n.sclOe = 1'b0;
                if (sleeping && otherWake && !s.slvMatch)
                begin
                    n.sdaOe = 1'b0;
                    n.st = S_IDLE;
                end
                else if (startDet || stopDet)
                begin
                    n.sdaOe = 1'b0;
                    n.bitCnt = 4'h0;
                    if (s.bitCnt != 4'h0)
                    begin
                        setEv = 1'b1;
                        code = ST_BUS_ERR;
                        n.st = S_IDLE;
                    end
                    else if (s.slvMatch)
                    begin
                        setEv = 1'b1;
                        code = ST_SLV_STOP;
                        n.slvMatch = 1'b0;
                        n.slvData = 1'b0;
                        n.slvTx = 1'b0;
                        n.st = startDet ? S_SLV : S_IDLE;
                    end
                    else if (stopDet)
                    begin
                        n.st = S_IDLE;
                    end
                end
                else
                begin
                    if (sclRise)
                    begin
                        if (s.bitCnt < 4'h8)
                            n.shreg = {s.shreg[6:0], sdaF};
                        else
                            n.ackBit = sdaF;
                    end
                    if (sclFall)
                    begin
                        n.bitCnt = s.bitCnt + 4'h1;
                        if (s.bitCnt == 4'h7)
                        begin
                            if (!s.slvMatch)
                            begin
                                if ((addrOwn || addrGen) && ackEnable)
                                begin
                                    n.sdaOe = 1'b1;
                                    n.slvMatch = 1'b1;
                                    n.slvTx = s.shreg[0];
                                    n.wake = sleeping;
                                end
                                else
                                begin
                                    n.bitCnt = 4'h0;
                                    n.st = S_IDLE;
                                end
                            end
                            else
                            begin
                                n.sdaOe = ~s.slvTx & ackEnable;
                            end
                        end
                        else if (s.bitCnt == 4'h8)
                        begin
                            n.sdaOe = 1'b0;
                            n.bitCnt = 4'h0;
                            n.sclOe = 1'b1;
                            n.st = S_SWAIT;
                            setEv = 1'b1;
                            if (!s.slvData)
                                code = addrOwn ? ST_SLV_ADDR : ST_SLV_GEN;
                            else if (s.slvTx)
                                code = ST_SLV_TX | {7'h00, s.ackBit};
                            else
                                code = ST_SLV_RX | {7'h00, s.ackBit};
                        end
                        else if (s.slvTx && s.slvData)
                        begin
                            n.sdaOe = ~s.shreg[7];
                        end
                    end
                end
            end
            S_SWAIT:
            begin
                n.sclOe = 1'b1;
                if (clearEvent && s.evFlag)
                begin
                    n.sclOe = 1'b0;
                    n.slvData = 1'b1;
                    n.st = S_SLV;
                    // A refused byte ends the slave's part of the transfer
                    if (s.slvTx && s.slvData && s.ackBit)
                    begin
                        n.slvMatch = 1'b0;
                        n.st = S_IDLE;
                    end
                    else if (s.slvTx)
                    begin
                        n.sdaOe = ~s.shreg[7];
                    end
                end
            end
            default:
            begin
                n.st = S_IDLE;
                n.sclOe = 1'b0;
                n.sdaOe = 1'b0;
            end
        endcase
        if (!enable)
        begin
            n.st = S_IDLE;
            n.sclOe = 1'b0;
            n.sdaOe = 1'b0;
        end
        if (setEv)
            n.evCode = code;
        // A new event wins over a clear in the same cycle
        n.evFlag = setEv | (s.evFlag & ~clearEvent);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            s <= RST_VAL;
        else
            s <= n;
    end

    assign sclOut = s.lineLow;
    assign sdaOut = s.lineLow;
    assign sclOe = s.sclOe;
    assign sdaOe = s.sdaOe;
    assign eventFlag = s.evFlag;
    assign status = s.status;
    assign dataOut = s.shreg;
    assign wakeReq = s.wake;
    assign busBusy = s.busy;

    // ==========================================
    // Checks
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence seqStartSent;
        s.st == S_MSTART && n.st == S_MWAIT;
    endsequence

    sequence seqSlaveEvent;
        s.st == S_SLV && n.st == S_SWAIT;
    endsequence

    chk_status_load: assert property ($rose(s.evFlag) |=> s.status == $past(s.evCode))
        else $error("status not loaded after event");
    chk_status_none: assert property (!s.evFlag |=> s.status == ST_NONE)
        else $error("status not idle code");
    chk_scl_hold: assert property (s.evFlag && (s.st == S_MWAIT || s.st == S_SWAIT) |-> s.sclOe)
        else $error("clock not held during event");
    chk_start_event: assert property (seqStartSent |=> s.evFlag && s.sclOe
        && (s.evCode == ST_START || s.evCode == ST_RSTART))
        else $error("no event after start");
    chk_master_abort: assert property (s.st == S_MBIT && n.st == S_IDLE && enable
        |=> s.evFlag && (s.evCode == ST_ARB_LOST || s.evCode == ST_BUS_ERR))
        else $error("abort without event");
    chk_slave_event: assert property (seqSlaveEvent |=> s.evFlag && s.sclOe ##1 s.status == s.evCode)
        else $error("slave event not posted");
    chk_release_go: assert property (s.st == S_MWAIT && s.evFlag && clearEvent |=> s.st != S_MWAIT)
        else $error("no resume after clear");
    chk_low_phase: assert property (s.st == S_MBIT && s.sclOe && s.setDone && s.cnt >= halfEnd
        |=> !s.sclOe)
        else $error("low phase overran");
    chk_stretch_wait: assert property (s.st == S_MBIT && !s.sclOe && !sclF |=> !s.sclOe)
        else $error("clock pulled low during stretch");
    chk_wake_abort: assert property (s.st == S_SLV && sleeping && otherWake && !s.slvMatch
        |=> s.st == S_IDLE)
        else $error("address match not aborted");

endmodule : tws_controller

// ==== tb/tws_bus_model.sv ====
`timescale 1ns/10ps
module tws_bus_model
#(
    parameter logic [6:0] MY_ADDR = 7'h5a
)
(
    input wire logic mclk,
    input wire logic sclOe,
    input wire logic sdaOe,
    output logic scl,
    output logic sda
);
    logic ack = 1'b0;
    logic sclQ = 1'b1;
    logic sdaQ = 1'b1;
    int nBits = 0;
    logic [7:0] shiftIn = 8'h00;
    // ==========================================
    // Wires: pull-ups, so a released line reads high
    assign scl = !sclOe;
    assign sda = !(sdaOe || ack);
    always @(posedge mclk)
    begin
        sclQ <= scl;
        sdaQ <= sda;
        if (scl && sclQ && sdaQ && !sda)
        begin
            nBits <= 0;
        end
        else if (scl && !sclQ)
        begin
            shiftIn <= {shiftIn[6:0], sda};
            nBits <= nBits + 1;
        end
        else if (!scl && sclQ)
        begin
            ack <= (nBits == 8) && (shiftIn[7:1] == MY_ADDR);
        end
    end
endmodule : tws_bus_model

// ==== tb/two_wire_serial_controller_bench.sv ====
`timescale 1ns/10ps
module two_wire_serial_controller_bench;
    import tws_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic startReq = 1'b0;
    logic stopReq = 1'b0;
    logic clearEvent = 1'b0;
    logic dataLoad = 1'b0;
    logic [7:0] dataIn = 8'h00;
    logic [7:0] div = 8'h04;
    logic [1:0] ps = 2'h0;
    logic ackEn = 1'b1;
    logic scl, sda, sclOe, sdaOe, eventFlag, busBusy;
    logic [7:0] status;
    logic sclQ = 1'b1;
    int cyc = 0;
    int period = 0;
    int miscompares = 0;
    int nChecks = 0;
    always #5 mclk = !mclk;
    tws_controller dut_u (.mclk(mclk), .rst_b(rst_b), .enable(1'b1), .startReq(startReq),
        .stopReq(stopReq), .ackEnable(ackEn), .clearEvent(clearEvent), .dataLoad(dataLoad),
        .dataIn(dataIn), .ownAddr(7'h33), .generalCallEnable(1'b0), .bitRateDivider(div),
        .prescalerSelect(ps), .sleeping(1'b0), .otherWake(1'b0), .sclIn(scl), .sdaIn(sda),
        .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe), .eventFlag(eventFlag),
        .status(status), .dataOut(), .wakeReq(), .busBusy(busBusy));
    tws_bus_model bus_u (.mclk(mclk), .sclOe(sclOe), .sdaOe(sdaOe), .scl(scl), .sda(sda));
    // ==========================================
    // Clock-line period, rise to rise
    always @(posedge mclk)
    begin
        sclQ <= scl;
        cyc <= cyc + 1;
        if (scl && !sclQ)
        begin
            period <= cyc;
            cyc <= 1;
        end
    end
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        nChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task wrap_up;
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task pulse(input int which);
        @(posedge mclk);
        if (which == 0) clearEvent <= 1'b1; else dataLoad <= 1'b1;
        @(posedge mclk);
        clearEvent <= 1'b0;
        dataLoad <= 1'b0;
    endtask : pulse
    // Bounded wait; status checked one cycle after the flag
    task wait_event(input logic [7:0] code);
        int i;
        // Flag is looked at only after an edge has settled, never a stale one
        for (i = 0; i < 2000; i++)
        begin
            @(posedge mclk);
            #1;
            if (eventFlag === 1'b1)
                break;
        end
        if (i == 2000)
        begin
            miscompares++;
            wrap_up();
        end
        else
        begin
            @(posedge mclk);
            #1;
            check("status", {8'h00, code}, {8'h00, status});
            check("hold", 16'h0001, {15'h0, sclOe});
        end
    endtask : wait_event
    // ==========================================
    // Sequence: start, address acked, restart, address refused, stop
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        check("status", {8'h00, ST_NONE}, {8'h00, status});
        check("flag", 16'h0000, {15'h0, eventFlag});
        for (int k = 0; k < 2; k++)
        begin
            @(posedge mclk);
            startReq <= 1'b1;
            if (k > 0) pulse(0);
            wait_event(k > 0 ? ST_RSTART : ST_START);
            check("busy", 16'h0001, {15'h0, busBusy});
            @(posedge mclk);
            startReq <= 1'b0;
            dataIn <= k > 0 ? 8'h22 : 8'hb4;
            div <= k > 0 ? 8'h02 : 8'h04;
            ps <= k > 0 ? 2'h1 : 2'h0;
            pulse(1);
            pulse(0);
            wait_event(k > 0 ? ST_MT_ADDR | 8'h01 : ST_MT_ADDR);
            check("period", k > 0 ? 16'd32 : 16'd24, period[15:0]);
        end
        @(posedge mclk);
        stopReq <= 1'b1;
        pulse(0);
        stopReq <= 1'b0;
        repeat (200) @(posedge mclk);
        #1;
        check("busy", 16'h0000, {15'h0, busBusy});
        check("status", {8'h00, ST_NONE}, {8'h00, status});
        check("hold", 16'h0000, {15'h0, sclOe});
        wrap_up();
    end
endmodule : two_wire_serial_controller_bench
